/* core/iodec_io_space.sv */
// module: lower i/o register space decoder and register bank
`timescale 1ns/1ps
`default_nettype none
module iodec_io_space
  import iodec_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  // core request and answer
  input wire iodec_req_s req_i,
  output iodec_rsp_s rsp_o,
  // peripheral status and live inputs
  input wire iodec_evt_s evt_i,
  input wire logic [7:0] port_b_pins_i,
  input wire logic [7:0] port_c_pins_i,
  input wire logic [7:0] port_d_pins_i,
  input wire logic comparator_out_i,
  // register contents toward the peripherals
  output logic [7:0] port_b_dir_o,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_c_dir_o,
  output logic [7:0] port_c_out_o,
  output logic [7:0] port_d_dir_o,
  output logic [7:0] port_d_out_o,
  output logic [15:0] eeprom_addr_o,
  output logic [7:0] eeprom_control_o,
  output logic [7:0] ext_int_mask_o,
  output logic [7:0] timer0_ctrl_a_o,
  output logic [7:0] timer0_ctrl_b_o,
  output logic [7:0] timer0_count_o,
  output logic [7:0] timer0_cmp_a_o,
  output logic [7:0] timer0_cmp_b_o,
  output logic [7:0] prescaler_ctrl_o,
  output logic [7:0] spi_control_o,
  output logic [7:0] spi_data_o,
  output logic [7:0] sleep_control_o,
  output logic [7:0] micro_control_o
);

  // three-stage pin synchronisers
  logic [23:0] pin_s1;
  logic [23:0] pin_s2;
  logic [23:0] pin_s3;
  logic [23:0] pin_val;
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_s3;
  logic cmp_val;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_val <= '0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_val <= 1'b0;
    end else if (enable_i) begin
      pin_s1 <= {port_d_pins_i, port_c_pins_i, port_b_pins_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_val <= (pin_s2 == pin_s3) ? pin_s2 : pin_val;
      cmp_s1 <= comparator_out_i;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      cmp_val <= (cmp_s2 == cmp_s3) ? cmp_s2 : cmp_val;
    end
  end

  // address mapping between i/o and data space
  wire io_acc = req_i.io_read | req_i.io_write; // RQ7
  wire bit_acc = req_i.set_bit_op | req_i.clear_bit_op; // RQ3
  wire mem_acc = req_i.memory_read_op | req_i.memory_write_op;
  wire [7:0] ds_rel = req_i.addr - IODEC_DS_OFS; // RQ8
  wire mem_io = mem_acc && req_i.addr >= IODEC_DS_OFS
                && req_i.addr <= IODEC_DS_END; // RQ8
  wire ext_hit = mem_acc && req_i.addr >= IODEC_EXT_LO; // RQ9
  // io instructions take only a 6-bit field
  wire [5:0] io_addr = mem_acc ? ds_rel[5:0]
                               : req_i.addr[IODEC_IO_W-1:0]; // RQ10
  wire low_addr = io_addr <= IODEC_BIT_TOP;
  wire bit_ok = bit_acc && low_addr && !mem_acc; // RQ3
  wire test_ok = req_i.skip_test && low_addr && !mem_acc; // RQ4
  wire wr_any = req_i.io_write | (mem_io & req_i.memory_write_op);
  wire do_wr = enable_i & wr_any & ~bit_acc;
  wire do_bit = enable_i & bit_ok;
  wire [7:0] bit_mask = 8'h01 << req_i.bit_sel;

  // current register bank
  // port registers
  logic [7:0] r_b_dir;
  logic [7:0] r_b_out;
  logic [7:0] r_c_dir;
  logic [7:0] r_c_out;
  logic [7:0] r_d_dir;
  logic [7:0] r_d_out;
  // flag registers
  logic [7:0] r_t0f;
  logic [7:0] r_t1f;
  logic [7:0] r_t2f;
  logic [7:0] r_pcf;
  logic [7:0] r_eif;
  logic [7:0] r_rst;
  // control, data and mixed registers
  logic [7:0] r_eim;
  logic [7:0] r_gp0;
  logic [7:0] r_eec;
  logic [7:0] r_eal;
  logic [7:0] r_eah;
  logic [7:0] r_psc;
  logic [7:0] r_t0a;
  logic [7:0] r_t0b;
  logic [7:0] r_t0c;
  logic [7:0] r_oca;
  logic [7:0] r_ocb;
  logic [7:0] r_gp1;
  logic [7:0] r_gp2;
  logic [7:0] r_spc;
  logic [7:0] r_sps;
  logic [7:0] r_spd;
  logic [7:0] r_cmp;
  logic [7:0] r_slp;
  logic [7:0] r_mcu;

  // read multiplexer, reserved space reads zero
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (io_addr)
      A_PORT_B_IN: rd_byte = pin_val[7:0];
      A_PORT_B_DIR: rd_byte = r_b_dir;
      A_PORT_B_OUT: rd_byte = r_b_out;
      A_PORT_C_IN: rd_byte = pin_val[15:8] & M_PORT_C;
      A_PORT_C_DIR: rd_byte = r_c_dir;
      A_PORT_C_OUT: rd_byte = r_c_out;
      A_PORT_D_IN: rd_byte = pin_val[23:16];
      A_PORT_D_DIR: rd_byte = r_d_dir;
      A_PORT_D_OUT: rd_byte = r_d_out;
      A_TIMER0_FLAGS: rd_byte = r_t0f;
      A_TIMER1_FLAGS: rd_byte = r_t1f;
      A_TIMER2_FLAGS: rd_byte = r_t2f;
      A_PIN_CHANGE_FLAGS: rd_byte = r_pcf;
      A_EXT_INT_FLAGS: rd_byte = r_eif;
      A_EXT_INT_MASK: rd_byte = r_eim;
      A_SCRATCH_0: rd_byte = r_gp0;
      A_EEPROM_CONTROL: rd_byte = r_eec;
      A_EEPROM_ADDR_LOW: rd_byte = r_eal; // RQ11
      A_EEPROM_ADDR_HIGH: rd_byte = r_eah; // RQ11
      A_PRESCALER_CTRL: rd_byte = r_psc;
      A_TIMER0_CTRL_A: rd_byte = r_t0a;
      A_TIMER0_CTRL_B: rd_byte = r_t0b;
      A_TIMER0_COUNT: rd_byte = r_t0c;
      A_TIMER0_CMP_A: rd_byte = r_oca;
      A_TIMER0_CMP_B: rd_byte = r_ocb;
      A_SCRATCH_1: rd_byte = r_gp1;
      A_SCRATCH_2: rd_byte = r_gp2;
      A_SPI_CONTROL: rd_byte = r_spc;
      A_SPI_STATUS: rd_byte = r_sps;
      A_SPI_DATA: rd_byte = r_spd;
      A_COMPARATOR: rd_byte = (r_cmp & ~M_CMP_OUT)
                              | (cmp_val ? M_CMP_OUT : 8'h00);
      A_SLEEP_CONTROL: rd_byte = r_slp;
      A_RESET_CAUSE: rd_byte = r_rst;
      A_MICRO_CONTROL: rd_byte = r_mcu;
      default: begin
        rd_byte = 8'h00; // RQ12
        rd_hit = 1'b0;
      end
    endcase
  end

  // value of a plain register after this cycle's access
  function automatic logic [7:0] upd_rw(input logic [7:0] cur,
      input logic sel, input logic [7:0] msk);
    logic [7:0] res;
    res = cur;
    if (sel && do_wr) begin
      res = req_i.wdata & msk; // RQ12
    end else if (sel && do_bit && req_i.set_bit_op) begin
      res = cur | (bit_mask & msk); // RQ6
    end else if (sel && do_bit) begin
      res = cur & ~bit_mask; // RQ6
    end
    return res;
  endfunction

  // value of a flag register: set wins over clear
  function automatic logic [7:0] upd_w1c(input logic [7:0] cur,
      input logic sel, input logic [7:0] msk, input logic [7:0] evt);
    logic [7:0] clr;
    clr = 8'h00;
    if (sel && do_wr) begin
      clr = req_i.wdata & msk; // RQ5
    end else if (sel && do_bit && req_i.set_bit_op) begin
      clr = bit_mask & msk; // RQ6
    end
    return ((cur & ~clr) | (evt & msk)) & msk;
  endfunction

  // register selects
  wire s_t0f = io_addr == A_TIMER0_FLAGS;
  wire s_t1f = io_addr == A_TIMER1_FLAGS;
  wire s_t2f = io_addr == A_TIMER2_FLAGS;
  wire s_pcf = io_addr == A_PIN_CHANGE_FLAGS;
  wire s_eif = io_addr == A_EXT_INT_FLAGS;
  wire s_sps = io_addr == A_SPI_STATUS;
  wire s_cmp = io_addr == A_COMPARATOR;
  wire s_rst = io_addr == A_RESET_CAUSE;
  wire ev_en = enable_i;

  // mixed registers: control part rw, flag part w1c
  // a process, so the helpers' hidden request inputs also wake it
  logic [7:0] sps_rw;
  logic [7:0] sps_fl;
  logic [7:0] cmp_rw;
  logic [7:0] cmp_fl;
  always_comb begin
    sps_rw = upd_rw(r_sps, s_sps, M_SPI_STATUS & ~M_SPI_ST_FLAGS);
    sps_fl = upd_w1c(r_sps, s_sps, M_SPI_ST_FLAGS, evt_i.spi);
    cmp_rw = upd_rw(r_cmp, s_cmp, M_COMPARATOR & ~M_CMP_FLAG);
    cmp_fl = upd_w1c(r_cmp, s_cmp, M_CMP_FLAG, evt_i.comparator);
  end

  // register bank update
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_b_dir <= '0;
      r_b_out <= '0;
      r_c_dir <= '0;
      r_c_out <= '0;
      r_d_dir <= '0;
      r_d_out <= '0;
      r_t0f <= '0;
      r_t1f <= '0;
      r_t2f <= '0;
      r_pcf <= '0;
      r_eif <= '0;
      r_eim <= '0;
      r_gp0 <= '0;
      r_eec <= '0;
      r_eal <= '0;
      r_eah <= '0;
      r_psc <= '0;
      r_t0a <= '0;
      r_t0b <= '0;
      r_t0c <= '0;
      r_oca <= '0;
      r_ocb <= '0;
      r_gp1 <= '0;
      r_gp2 <= '0;
      r_spc <= '0;
      r_sps <= '0;
      r_spd <= '0;
      r_cmp <= '0;
      r_slp <= '0;
      r_rst <= '0;
      r_mcu <= IODEC_RST_BYTE;
    end else if (ev_en) begin
      r_b_dir <= upd_rw(r_b_dir, io_addr == A_PORT_B_DIR, M_FULL);
      r_b_out <= upd_rw(r_b_out, io_addr == A_PORT_B_OUT, M_FULL);
      r_c_dir <= upd_rw(r_c_dir, io_addr == A_PORT_C_DIR, M_PORT_C);
      r_c_out <= upd_rw(r_c_out, io_addr == A_PORT_C_OUT, M_PORT_C);
      r_d_dir <= upd_rw(r_d_dir, io_addr == A_PORT_D_DIR, M_FULL);
      r_d_out <= upd_rw(r_d_out, io_addr == A_PORT_D_OUT, M_FULL);
      r_t0f <= upd_w1c(r_t0f, s_t0f, M_T0_FLAGS, evt_i.timer0); // RQ5
      r_t1f <= upd_w1c(r_t1f, s_t1f, M_T1_FLAGS, evt_i.timer1); // RQ5
      r_t2f <= upd_w1c(r_t2f, s_t2f, M_T2_FLAGS, evt_i.timer2); // RQ5
      r_pcf <= upd_w1c(r_pcf, s_pcf, M_PC_FLAGS, evt_i.pin_change);
      r_eif <= upd_w1c(r_eif, s_eif, M_EI_FLAGS, evt_i.ext_int);
      r_eim <= upd_rw(r_eim, io_addr == A_EXT_INT_MASK, M_EI_MASK);
      r_gp0 <= upd_rw(r_gp0, io_addr == A_SCRATCH_0, M_FULL);
      r_eec <= upd_rw(r_eec, io_addr == A_EEPROM_CONTROL, M_EE_CTRL);
      r_eal <= upd_rw(r_eal, io_addr == A_EEPROM_ADDR_LOW, M_FULL);
      r_eah <= upd_rw(r_eah, io_addr == A_EEPROM_ADDR_HIGH, M_EE_HIGH);
      r_psc <= upd_rw(r_psc, io_addr == A_PRESCALER_CTRL, M_PRESCALER);
      r_t0a <= upd_rw(r_t0a, io_addr == A_TIMER0_CTRL_A, M_T0_CTRL_A);
      r_t0b <= upd_rw(r_t0b, io_addr == A_TIMER0_CTRL_B, M_T0_CTRL_B);
      r_t0c <= upd_rw(r_t0c, io_addr == A_TIMER0_COUNT, M_FULL);
      r_oca <= upd_rw(r_oca, io_addr == A_TIMER0_CMP_A, M_FULL);
      r_ocb <= upd_rw(r_ocb, io_addr == A_TIMER0_CMP_B, M_FULL);
      r_gp1 <= upd_rw(r_gp1, io_addr == A_SCRATCH_1, M_FULL);
      r_gp2 <= upd_rw(r_gp2, io_addr == A_SCRATCH_2, M_FULL);
      r_spc <= upd_rw(r_spc, io_addr == A_SPI_CONTROL, M_FULL);
      r_sps <= (sps_rw & ~M_SPI_ST_FLAGS) | sps_fl;
      r_spd <= upd_rw(r_spd, io_addr == A_SPI_DATA, M_FULL);
      r_cmp <= (cmp_rw & ~M_CMP_FLAG) | cmp_fl;
      r_slp <= upd_rw(r_slp, io_addr == A_SLEEP_CONTROL, M_SLEEP);
      r_rst <= upd_w1c(r_rst, s_rst, M_RESET_CAUSE, evt_i.reset_cause);
      r_mcu <= upd_rw(r_mcu, io_addr == A_MICRO_CONTROL, M_MICRO_CTRL);
    end
  end

  // answer to the core, registered
  wire rd_req = req_i.io_read | (mem_io & req_i.memory_read_op)
                | test_ok;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_o <= '0;
    end else if (enable_i) begin
      rsp_o.rdata <= rd_req ? rd_byte : 8'h00;
      rsp_o.bit_value <= test_ok & rd_byte[req_i.bit_sel]; // RQ4
      rsp_o.hit <= rd_hit & (io_acc | mem_io | bit_ok | test_ok);
      rsp_o.ext_sel <= ext_hit & ~io_acc; // RQ9
    end
  end

  // register contents toward peripherals
  assign port_b_dir_o = r_b_dir;
  assign port_b_out_o = r_b_out;
  assign port_c_dir_o = r_c_dir;
  assign port_c_out_o = r_c_out;
  assign port_d_dir_o = r_d_dir;
  assign port_d_out_o = r_d_out;
  assign eeprom_addr_o = {r_eah, r_eal}; // RQ11
  assign eeprom_control_o = r_eec;
  assign ext_int_mask_o = r_eim;
  assign timer0_ctrl_a_o = r_t0a;
  assign timer0_ctrl_b_o = r_t0b;
  assign timer0_count_o = r_t0c;
  assign timer0_cmp_a_o = r_oca;
  assign timer0_cmp_b_o = r_ocb;
  assign prescaler_ctrl_o = r_psc;
  assign spi_control_o = r_spc;
  assign spi_data_o = r_spd;
  assign sleep_control_o = r_slp;
  assign micro_control_o = r_mcu;

  // checks
  a_bit_high_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.set_bit_op && req_i.addr[5:0] == A_SPI_CONTROL
    && !mem_acc |=> $stable(r_spc)) // RQ3
    else $error("bit op changed a high register");
  a_bit_test_val: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && test_ok && io_addr == A_SCRATCH_0
    |=> rsp_o.bit_value == $past(r_gp0[req_i.bit_sel])) // RQ4
    else $error("bit test returned wrong value");
  a_w1c_zero_keep: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.io_write && s_t0f && req_i.wdata == 8'h00
    && evt_i.timer0 == 8'h00 |=> r_t0f == $past(r_t0f)) // RQ5
    else $error("zero write changed a flag");
  a_w1c_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.io_write && s_t0f && evt_i.timer0 == 8'h00
    |=> (r_t0f & $past(req_i.wdata)) == 8'h00) // RQ5
    else $error("one write left a flag set");
  a_bit_only_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    do_bit && io_addr == A_SCRATCH_0
    |=> ((r_gp0 ^ $past(r_gp0)) & ~$past(bit_mask)) == 8'h00) // RQ6
    else $error("bit op touched other bits");
  a_io_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.io_write && req_i.addr[5:0] == A_SCRATCH_1
    |=> r_gp1 == $past(req_i.wdata)) // RQ7
    else $error("io write missed its register");
  a_ds_offset: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.memory_write_op && !bit_acc
    && req_i.addr == A_SCRATCH_2 + IODEC_DS_OFS
    |=> r_gp2 == $past(req_i.wdata)) // RQ8
    else $error("data-space offset wrong");
  a_ext_mem_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && io_acc |=> !rsp_o.ext_sel) // RQ9
    else $error("io instruction reached extended space");
  a_eeaddr_pair: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.io_write && req_i.addr[5:0] == A_EEPROM_ADDR_LOW
    |=> eeprom_addr_o[7:0] == $past(req_i.wdata)) // RQ11
    else $error("memory address low byte misplaced");
  a_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    enable_i && req_i.io_read && req_i.addr[5:0] == 6'h29
    |=> rsp_o.rdata == 8'h00 && !rsp_o.hit) // RQ12
    else $error("reserved address read non-zero");
  c_bit_set: cover property (@(posedge clock_i) do_bit && req_i.set_bit_op);
  c_w1c_race: cover property (@(posedge clock_i)
    do_wr && s_t0f && evt_i.timer0 != 8'h00);
  c_ds_read: cover property (@(posedge clock_i)
    enable_i && mem_io && req_i.memory_read_op);
  c_ext: cover property (@(posedge clock_i) enable_i && ext_hit);

endmodule
`default_nettype wire

/* core/iodec_pkg.sv */
// package: constants and carriers for the i/o register space decoder
// Functional notes
// RQ1: software writes zero into reserved bit positions of any register.
// RQ2: software never writes an i/o address marked reserved.
// RQ3: single-bit set and clear work on i/o addresses 0x00..0x1F only.
// RQ4: skip-if-bit tests read one selected bit in the low 32 addresses.
// RQ5: some status flags clear on writing one; writing zero leaves them.
// RQ6: single-bit set or clear changes only the addressed bit.
// RQ7: dedicated i/o read and write use i/o addresses 0x00..0x3F.
// RQ8: data-space address of an i/o register is its i/o address plus 0x20.
// RQ9: extended space 0x60..0xFF is reachable by data-space access only.
// RQ10: the dedicated i/o address field covers exactly 64 locations.
// RQ11: memory address low byte sits at 0x21, high byte at 0x22.
// RQ12: reserved addresses and bits read zero; writes to them do nothing.
package iodec_pkg;
  localparam int unsigned IODEC_IO_W = 6;
  localparam logic [7:0] IODEC_DS_OFS = 8'h20;
  localparam logic [7:0] IODEC_DS_END = 8'h5f;
  localparam logic [7:0] IODEC_EXT_LO = 8'h60;
  localparam logic [5:0] IODEC_BIT_TOP = 6'h1f;
  // register offsets
  localparam logic [5:0] A_PORT_B_IN = 6'h03;
  localparam logic [5:0] A_PORT_B_DIR = 6'h04;
  localparam logic [5:0] A_PORT_B_OUT = 6'h05;
  localparam logic [5:0] A_PORT_C_IN = 6'h06;
  localparam logic [5:0] A_PORT_C_DIR = 6'h07;
  localparam logic [5:0] A_PORT_C_OUT = 6'h08;
  localparam logic [5:0] A_PORT_D_IN = 6'h09;
  localparam logic [5:0] A_PORT_D_DIR = 6'h0a;
  localparam logic [5:0] A_PORT_D_OUT = 6'h0b;
  localparam logic [5:0] A_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] A_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] A_TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] A_PIN_CHANGE_FLAGS = 6'h1b;
  localparam logic [5:0] A_EXT_INT_FLAGS = 6'h1c;
  localparam logic [5:0] A_EXT_INT_MASK = 6'h1d;
  localparam logic [5:0] A_SCRATCH_0 = 6'h1e;
  localparam logic [5:0] A_EEPROM_CONTROL = 6'h1f;
  localparam logic [5:0] A_EEPROM_ADDR_LOW = 6'h21;
  localparam logic [5:0] A_EEPROM_ADDR_HIGH = 6'h22;
  localparam logic [5:0] A_PRESCALER_CTRL = 6'h23;
  localparam logic [5:0] A_TIMER0_CTRL_A = 6'h24;
  localparam logic [5:0] A_TIMER0_CTRL_B = 6'h25;
  localparam logic [5:0] A_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] A_TIMER0_CMP_A = 6'h27;
  localparam logic [5:0] A_TIMER0_CMP_B = 6'h28;
  localparam logic [5:0] A_SCRATCH_1 = 6'h2a;
  localparam logic [5:0] A_SCRATCH_2 = 6'h2b;
  localparam logic [5:0] A_SPI_CONTROL = 6'h2c;
  localparam logic [5:0] A_SPI_STATUS = 6'h2d;
  localparam logic [5:0] A_SPI_DATA = 6'h2e;
  localparam logic [5:0] A_COMPARATOR = 6'h30;
  localparam logic [5:0] A_SLEEP_CONTROL = 6'h33;
  localparam logic [5:0] A_RESET_CAUSE = 6'h34;
  localparam logic [5:0] A_MICRO_CONTROL = 6'h35;
  // implemented-bit masks; zero bits are reserved
  localparam logic [7:0] M_FULL = 8'hff;
  localparam logic [7:0] M_PORT_C = 8'h7f;
  localparam logic [7:0] M_T0_FLAGS = 8'h07;
  localparam logic [7:0] M_T1_FLAGS = 8'h27;
  localparam logic [7:0] M_T2_FLAGS = 8'h07;
  localparam logic [7:0] M_PC_FLAGS = 8'h07;
  localparam logic [7:0] M_EI_FLAGS = 8'h03;
  localparam logic [7:0] M_EI_MASK = 8'h03;
  localparam logic [7:0] M_EE_CTRL = 8'h3f;
  localparam logic [7:0] M_EE_HIGH = 8'h03;
  localparam logic [7:0] M_PRESCALER = 8'h83;
  localparam logic [7:0] M_T0_CTRL_A = 8'hf3;
  localparam logic [7:0] M_T0_CTRL_B = 8'hcf;
  localparam logic [7:0] M_SPI_STATUS = 8'hc1;
  localparam logic [7:0] M_SPI_ST_FLAGS = 8'hc0;
  localparam logic [7:0] M_COMPARATOR = 8'hdf;
  localparam logic [7:0] M_CMP_FLAG = 8'h10;
  localparam logic [7:0] M_CMP_OUT = 8'h20;
  localparam logic [7:0] M_SLEEP = 8'h0f;
  localparam logic [7:0] M_RESET_CAUSE = 8'h0f;
  localparam logic [7:0] M_MICRO_CTRL = 8'h73;
  localparam logic [7:0] IODEC_RST_BYTE = 8'h00;
  // access kinds presented by the core
  typedef enum logic [4:0] {
    IODEC_OP_IDLE = 5'b00001,
    IODEC_OP_IO_RD = 5'b00010,
    IODEC_OP_IO_WR = 5'b00100,
    IODEC_OP_BIT = 5'b01000,
    IODEC_OP_MEM = 5'b10000
  } iodec_op_e;
  // one request from the core
  typedef struct packed {
    logic io_read;
    logic io_write;
    logic set_bit_op;
    logic clear_bit_op;
    logic skip_test;
    logic memory_read_op;
    logic memory_write_op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iodec_req_s;
  // answer to the core
  typedef struct packed {
    logic [7:0] rdata;
    logic bit_value;
    logic hit;
    logic ext_sel;
  } iodec_rsp_s;
  // hardware status events, one pulse per flag
  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] timer2;
    logic [7:0] pin_change;
    logic [7:0] ext_int;
    logic [7:0] spi;
    logic [7:0] comparator;
    logic [7:0] reset_cause;
  } iodec_evt_s;
endpackage

/* verification/iodec_core_model.sv */
// core-side model issuing i/o, bit-op and data-space requests
`timescale 1ns/1ps
`default_nettype none
module iodec_core_model
  import iodec_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request toward the decoder and its answer
  output var iodec_req_s req_o,
  input wire iodec_rsp_s rsp_i
);
  // set only by a scenario that writes reserved places or bits on purpose
  logic allow_bad = 1'b0;
  initial req_o = '0;
  // one request held for one edge; answer read just after that edge
  task automatic op(input logic [6:0] k, input logic [7:0] a,
      input logic [2:0] b, input logic [7:0] d, output iodec_rsp_s r);
    logic bad;
    bad = k[5] && !allow_bad && (a[5:0] inside {[0:2], [12:20], [24:26],
      32, 41, 47, 49, 50, 54, [56:60]});
    @(posedge clock_i);
    if (!bad) begin
      req_o <= {k, a, b, d};
    end
    @(posedge clock_i);
    req_o <= '0;
    #1;
    r = rsp_i;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iodec_pkg::*;
  // request kinds, one-hot in request field order
  localparam logic [6:0] K_RD = 7'h40;
  localparam logic [6:0] K_WR = 7'h20;
  localparam logic [6:0] K_SET = 7'h10;
  localparam logic [6:0] K_CLR = 7'h08;
  localparam logic [6:0] K_SKP = 7'h04;
  localparam logic [6:0] K_MRD = 7'h02;
  localparam logic [6:0] K_MWR = 7'h01;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  iodec_evt_s evt_i = '0;
  logic [7:0] pins_b = 8'h00;
  logic [7:0] pins_c = 8'h00;
  logic [7:0] pins_d = 8'h00;
  logic cmp_out = 1'b0;
  iodec_req_s req;
  iodec_rsp_s rsp;
  iodec_rsp_s r;
  logic [7:0] b_dir;
  logic [15:0] ee_addr;
  int num_errors = 0;
  int compares = 0;
  // 25 MHz clock
  always #20 clock_i = ~clock_i;
  iodec_io_space iodec_io_space_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(1'b1),
    .req_i(req), .rsp_o(rsp), .evt_i(evt_i),
    .port_b_pins_i(pins_b), .port_c_pins_i(pins_c),
    .port_d_pins_i(pins_d), .comparator_out_i(cmp_out),
    .port_b_dir_o(b_dir), .port_b_out_o(), .port_c_dir_o(),
    .port_c_out_o(), .port_d_dir_o(), .port_d_out_o(),
    .eeprom_addr_o(ee_addr), .eeprom_control_o(), .ext_int_mask_o(),
    .timer0_ctrl_a_o(), .timer0_ctrl_b_o(), .timer0_count_o(),
    .timer0_cmp_a_o(), .timer0_cmp_b_o(), .prescaler_ctrl_o(),
    .spi_control_o(), .spi_data_o(), .sleep_control_o(),
    .micro_control_o()
  );
  iodec_core_model iodec_core_model_inst (
    .clock_i(clock_i), .req_o(req), .rsp_i(rsp)
  );
  // compare and count
  task automatic check(input string n, input logic [15:0] e,
      input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one request through the core model
  task automatic go(input logic [6:0] k, input logic [7:0] a,
      input logic [2:0] b = 3'h0, input logic [7:0] d = 8'h00);
    iodec_core_model_inst.op(k, a, b, d, r);
  endtask
  // read/write every plain register except eeprom control (0x1f) by both access paths
  task automatic t_regs;
    logic [7:0] ofs [22] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b,
      8'h1d, 8'h1e, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
      8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h2e, 8'h33, 8'h35};
    logic [7:0] msk [22] = '{8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff,
      8'h03, 8'hff, 8'hff, 8'h03, 8'h83, 8'hf3, 8'hcf, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h73};
    for (int i = 0; i < 22; i++) begin
      go(K_RD, ofs[i]);
      check("reset value", 8'h00, r.rdata);
      go(K_WR, ofs[i], 3'h0, msk[i]);
      go(K_MRD, ofs[i] + 8'h20);
      check("data-space read", msk[i], r.rdata);
      check("hit", 1'b1, r.hit);
      go(K_MWR, ofs[i] + 8'h20, 3'h0, 8'h00);
      go(K_RD, ofs[i]);
      check("io read", 8'h00, r.rdata);
    end
    go(K_WR, 8'h21, 3'h0, 8'h34);
    go(K_WR, 8'h22, 3'h0, 8'h02);
    check("eeprom address", 16'h0234, ee_addr);
    go(K_MWR, 8'h24, 3'h0, 8'h5a);
    check("port b direction", 8'h5a, b_dir);
    $display("t_regs done");
  endtask
  // reserved places read zero and swallow writes
  task automatic t_reserved;
    logic [7:0] rs [10] = '{8'h00, 8'h02, 8'h0c, 8'h14, 8'h18, 8'h20,
      8'h29, 8'h2f, 8'h36, 8'h3c};
    go(K_WR, 8'h1e, 3'h0, 8'ha5);
    iodec_core_model_inst.allow_bad = 1'b1;
    for (int i = 0; i < 10; i++) begin
      go(K_WR, rs[i], 3'h0, 8'hff);
      go(K_RD, rs[i]);
      check("reserved read", 8'h00, r.rdata);
      check("reserved hit", 1'b0, r.hit);
    end
    go(K_WR, 8'h35, 3'h0, 8'hff);
    go(K_RD, 8'h35);
    check("reserved bits", 8'h73, r.rdata);
    iodec_core_model_inst.allow_bad = 1'b0;
    go(K_RD, 8'h1e);
    check("neighbour kept", 8'ha5, r.rdata);
    $display("t_reserved done");
  endtask
  // bit set, clear and test in the low 32, bit set and test above it
  task automatic t_bits;
    logic [7:0] v = 8'h5a;
    go(K_WR, 8'h1e, 3'h0, 8'h00);
    go(K_SET, 8'h1e, 3'h3);
    go(K_SET, 8'h1e, 3'h7);
    go(K_CLR, 8'h1e, 3'h3);
    go(K_RD, 8'h1e);
    check("bit ops low", 8'h80, r.rdata);
    go(K_WR, 8'h2c, 3'h0, 8'h00);
    go(K_SET, 8'h2c, 3'h0);
    go(K_RD, 8'h2c);
    check("bit op high", 8'h00, r.rdata);
    go(K_WR, 8'h1e, 3'h0, v);
    for (int i = 0; i < 8; i++) begin
      go(K_SKP, 8'h1e, i[2:0]);
      check("bit test", v[i], r.bit_value);
    end
    go(K_WR, 8'h2a, 3'h0, 8'hff);
    go(K_SKP, 8'h2a, 3'h1);
    check("bit test high", 1'b0, r.bit_value);
    $display("t_bits done");
  endtask
  // write-one-to-clear flags
  task automatic t_flags;
    @(posedge clock_i) evt_i <= '{timer0: 8'h07, timer1: 8'hff,
      default: 8'h00};
    @(posedge clock_i) evt_i <= '0;
    go(K_RD, 8'h16);
    check("timer1 flags", 8'h27, r.rdata);
    go(K_WR, 8'h15, 3'h0, 8'h02);
    go(K_RD, 8'h15);
    check("flag write one", 8'h05, r.rdata);
    go(K_WR, 8'h15, 3'h0, 8'h00);
    go(K_RD, 8'h15);
    check("flag write zero", 8'h05, r.rdata);
    go(K_SET, 8'h15, 3'h0);
    go(K_CLR, 8'h15, 3'h2);
    go(K_RD, 8'h15);
    check("flag bit op", 8'h04, r.rdata);
    // event and one-write on the same edge: the event wins
    fork
      go(K_WR, 8'h15, 3'h0, 8'h01);
      begin
        @(posedge clock_i) evt_i <= '{timer0: 8'h01, default: 8'h00};
        @(posedge clock_i) evt_i <= '0;
      end
    join
    go(K_RD, 8'h15);
    check("flag set wins", 8'h05, r.rdata);
    go(K_MWR, 8'h36, 3'h0, 8'h27);
    go(K_RD, 8'h16);
    check("flag data-space", 8'h00, r.rdata);
    $display("t_flags done");
  endtask
  // extended space and the 64-place io field
  task automatic t_space;
    go(K_MRD, 8'h60);
    check("ext select low", 1'b1, r.ext_sel);
    check("ext hit", 1'b0, r.hit);
    go(K_MRD, 8'hff);
    check("ext select top", 1'b1, r.ext_sel);
    go(K_MRD, 8'h5f);
    check("ext select edge", 1'b0, r.ext_sel);
    go(K_WR, 8'h1e, 3'h0, 8'h3c);
    go(K_RD, 8'hde);
    check("io field wraps", 8'h3c, r.rdata);
    $display("t_space done");
  endtask
  // synchronised pin and comparator inputs
  task automatic t_pins;
    @(posedge clock_i);
    pins_b <= 8'hc3;
    pins_c <= 8'hff;
    pins_d <= 8'h81;
    cmp_out <= 1'b1;
    repeat (4) @(posedge clock_i);
    go(K_WR, 8'h03, 3'h0, 8'h00);
    go(K_RD, 8'h03);
    check("port b pins", 8'hc3, r.rdata);
    go(K_RD, 8'h06);
    check("port c pins", 8'h7f, r.rdata);
    go(K_MRD, 8'h29);
    check("port d pins", 8'h81, r.rdata);
    go(K_MRD, 8'h50);
    check("comparator out", 8'h20, r.rdata & 8'h20);
    $display("t_pins done");
  endtask
  // counts and verdict
  task automatic results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #2000000;
    num_errors++;
    results();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_reserved();
    t_bits();
    t_flags();
    t_space();
    t_pins();
    results();
  end
endmodule
`default_nettype wire
